// *** logic/mhsp_map.svh ***
// offsets, field positions, reset values and timing of the host port
`ifndef MHSP_MAP_SVH
`define MHSP_MAP_SVH
`define MHSP_SEL_OFS    8'h50
`define MHSP_FLOW_BIT   2
`define MHSP_FLOW_RST   1'b0
`define MHSP_FS_RD_OFS  8'hCC
`define MHSP_FS_WR_OFS  8'h56
`define MHSP_I2C_ID0    8'h44
`define MHSP_I2C_ID1    8'h46
`define MHSP_SPI_WR_OP  8'h80
`define MHSP_SPI_RD_OP  8'h00
`define MHSP_CMD_OP     7:6
`define MHSP_CMD_CNT    5:0
`define MHSP_CLK_MHZ    200
`define MHSP_BIT_NS     1000
`define MHSP_BIT_CYC    ((`MHSP_BIT_NS * `MHSP_CLK_MHZ) / 1000)
`endif

// *** logic/mhsp_pkg.sv ***
// types shared by the host port modules
`default_nettype none
package mhsp_pkg;
  typedef enum logic [1:0] {MHSP_I2C, MHSP_SPI, MHSP_UART, MHSP_NONE}
    mhsp_mode_t;
  typedef enum logic [1:0] {UOP_BRST, UOP_WR, UOP_RD, UOP_STOP} mhsp_uop_t;
  typedef enum logic [2:0] {I2C_IDLE, I2C_DEV, I2C_REG, I2C_WR, I2C_RD}
    mhsp_i2c_st_t;
  typedef enum logic [2:0] {U_SKIP, U_CMD, U_ADDR, U_WR, U_RDC, U_RDO,
                            U_DRAIN} mhsp_uart_st_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP}
    mhsp_rx_st_t;
endpackage : mhsp_pkg
`default_nettype wire

// *** logic/mhsp_sync.sv ***
// three-stage pin synchroniser, output moves once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module mhsp_sync
  import mhsp_pkg::*;
#(
  parameter int W = 4
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lv;
  } mhsp_sync_st_t;
  mhsp_sync_st_t q, d;

  initial begin
    if (W < 1) $error("mhsp_sync: width must be at least one");
  end

  always_comb begin
    d    = q;
    d.s1 = async_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) d.lv[i] = q.s3[i];
    end
  end

  // idle pins sit high, so start from ones to avoid a false edge
  always_ff @(posedge sys_clk) begin
    if (rst) q <= '1;
    else q <= d;
  end

  assign level = q.lv;
endmodule : mhsp_sync
`default_nettype wire

// *** logic/mhsp_uart_tx.sv ***
// serial transmitter: start bit, eight data bits lsb first, stop bit
`timescale 1ns/1ps
`default_nettype none
`include "mhsp_map.svh"
module mhsp_uart_tx
  import mhsp_pkg::*;
#(
  parameter int BIT_CYC = `MHSP_BIT_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [7:0] data,
  output logic            busy,
  output logic            txd
);
  typedef struct packed {
    logic [8:0]  sh;
    logic [3:0]  nbit;
    logic [15:0] cnt;
    logic        busy;
    logic        txd;
  } mhsp_tx_st_t;
  mhsp_tx_st_t q, d;

  initial begin
    if (BIT_CYC < 4 || BIT_CYC > 65535) $error("mhsp_uart_tx: bad BIT_CYC");
  end

  always_comb begin
    d = q;
    if (!q.busy) begin
      if (start) begin
        d.sh   = {1'b1, data};
        d.txd  = 1'b0;
        d.nbit = 4'h9;
        d.cnt  = 16'(BIT_CYC - 1);
        d.busy = 1'b1;
      end
    end else if (q.cnt != 16'h0000) begin
      d.cnt = q.cnt - 16'h0001;
    end else if (q.nbit == 4'h0) begin
      d.busy = 1'b0;
    end else begin
      d.txd  = q.sh[0];
      d.sh   = {1'b1, q.sh[8:1]};
      d.nbit = q.nbit - 4'h1;
      d.cnt  = 16'(BIT_CYC - 1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q     <= '0;
      q.txd <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign busy = q.busy;
  assign txd  = q.txd;
endmodule : mhsp_uart_tx
`default_nettype wire

// *** logic/mhsp_port.sv ***
// host register port: spi, i2c and flow-controlled uart slaves
//------------------------------------------------------------------------
//------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "mhsp_map.svh"
module mhsp_port
  import mhsp_pkg::*;
#(
  parameter int BIT_CYC = `MHSP_BIT_CYC
) (
  input  wire logic [1:0]  detected_mode,
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        port_serial_clock_i,
  output logic             port_serial_clock_o,
  output logic             port_serial_clock_oe,
  input  wire logic        port_master_out_i,
  output logic             port_master_out_o,
  output logic             port_master_out_oe,
  input  wire logic        port_slave_out_i,
  output logic             port_slave_out_o,
  output logic             port_slave_out_oe,
  input  wire logic        port_select_rx_i,
  output logic      [7:0]  reg_addr,
  output logic      [7:0]  reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [7:0]  reg_rdata,
  output logic             fs_rd,
  input  wire logic [7:0]  fs_rdata,
  output logic             fs_wr,
  output logic      [63:0] fs_wdata
);
  //----------------------------------------------------------------------
  // state
  //----------------------------------------------------------------------
  typedef struct packed {
    mhsp_mode_t    mode;
    logic          fc_en;
    logic [7:0]    addr;
    logic [7:0]    reg_addr;
    logic [7:0]    reg_wdata;
    logic          reg_wr;
    logic          reg_rd;
    logic          fs_rd;
    logic          loc_rd;
    logic          fs_wr;
    logic [63:0]   fs_wdata;
    logic [55:0]   pk;
    logic [2:0]    pk_n;
    logic          sclk_p;
    logic          sda_p;
    logic          ss_p;
    logic [2:0]    spi_bit;
    logic [1:0]    spi_byte;
    logic          spi_wr;
    logic [7:0]    rx8;
    logic [7:0]    tx;
    mhsp_i2c_st_t  i2_st;
    logic [3:0]    i2_cnt;
    mhsp_rx_st_t   rx_st;
    logic [15:0]   rx_cnt;
    logic [2:0]    rx_bit;
    logic [7:0]    rx_sh;
    mhsp_uart_st_t u_st;
    mhsp_uop_t     u_op;
    logic [5:0]    u_cnt;
    logic          u_pend;
    logic          u_have;
    logic          tx_go;
    logic          sclk_o;
    logic          sclk_oe;
    logic          mo_o;
    logic          mo_oe;
    logic          so_o;
    logic          so_oe;
  } mhsp_port_st_t;
  mhsp_port_st_t q, d;

  logic [3:0] pins_s;
  logic       sclk_s, mo_s, so_s, ss_s;
  logic       tx_busy, txd_w;
  logic       rd_go, wr_go, rd_done, rx_byte, cts_hold;
  logic       sclk_rise, sclk_fall;
  logic [7:0] wb, rdat, bval;

  initial begin
    if (BIT_CYC < 4 || BIT_CYC > 65535) $error("mhsp_port: bad BIT_CYC");
  end

  function automatic logic [7:0] mhsp_inc(input logic [7:0] a);
    return a + 8'h01;
  endfunction : mhsp_inc

  mhsp_sync #(.W(4)) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({port_serial_clock_i, port_master_out_i,
                port_slave_out_i, port_select_rx_i}),
    .level    (pins_s)
  );
  assign {sclk_s, mo_s, so_s, ss_s} = pins_s;

  mhsp_uart_tx #(.BIT_CYC(BIT_CYC)) u_tx (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (q.tx_go),
    .data    (q.tx),
    .busy    (tx_busy),
    .txd     (txd_w)
  );

  assign sclk_rise = sclk_s & ~q.sclk_p;
  assign sclk_fall = ~sclk_s & q.sclk_p;
  assign rd_done   = q.reg_rd | q.fs_rd | q.loc_rd;
  assign cts_hold  = q.fc_en & so_s;
  assign rdat = q.fs_rd  ? fs_rdata :
                q.loc_rd ? {5'b0_0000, q.fc_en, q.mode} : reg_rdata;

  //----------------------------------------------------------------------
  // protocol engines
  //----------------------------------------------------------------------
  always_comb begin
    d        = q;
    rd_go    = 1'b0;
    wr_go    = 1'b0;
    rx_byte  = 1'b0;
    wb       = 8'h00;
    bval     = {q.rx8[6:0], mo_s};
    d.reg_wr = 1'b0;
    d.reg_rd = 1'b0;
    d.fs_rd  = 1'b0;
    d.loc_rd = 1'b0;
    d.fs_wr  = 1'b0;
    d.tx_go  = 1'b0;
    d.mode   = mhsp_mode_t'(detected_mode);
    d.sclk_p = sclk_s;
    d.sda_p  = so_s;
    d.ss_p   = ss_s;

    // spi: both served modes sample on rise and shift on fall
    if (q.mode == MHSP_SPI) begin
      d.so_oe = ~ss_s;
      if (ss_s) begin
        d.spi_bit  = 3'h0;
        d.spi_byte = 2'h0;
      end else if (sclk_rise) begin
        d.rx8     = bval;
        d.spi_bit = q.spi_bit + 3'h1;
        if (q.spi_bit == 3'h7) begin
          if (q.spi_byte != 2'h3) d.spi_byte = q.spi_byte + 2'h1;
          unique case (q.spi_byte)
            2'h0: d.spi_wr = (bval == `MHSP_SPI_WR_OP);
            2'h1: d.addr = bval;
            2'h2: rd_go = ~q.spi_wr;
            2'h3: begin
              rd_go = ~q.spi_wr;
              wr_go = q.spi_wr;
              wb    = bval;
            end
          endcase
        end
      end else if (sclk_fall) begin
        d.so_o = q.tx[7];
        d.tx   = {q.tx[6:0], 1'b0};
      end
      if (rd_done) d.tx = rdat;
    end

    // i2c: sda pulled low only by output enable, scl never driven
    if (q.mode == MHSP_I2C) begin
      d.so_o = 1'b0;
      if (q.sclk_p && sclk_s && q.sda_p && !so_s) begin
        d.i2_st  = I2C_DEV;
        d.i2_cnt = 4'h0;
        d.so_oe  = 1'b0;
      end else if (q.sclk_p && sclk_s && !q.sda_p && so_s) begin
        d.i2_st = I2C_IDLE;
        d.so_oe = 1'b0;
      end else if (q.i2_st != I2C_IDLE) begin
        if (sclk_rise) begin
          d.i2_cnt = q.i2_cnt + 4'h1;
          if (q.i2_cnt < 4'h8) d.rx8 = {q.rx8[6:0], so_s};
          else if (q.i2_st == I2C_RD) begin
            if (so_s) d.i2_st = I2C_IDLE;
            else rd_go = 1'b1;
          end
        end else if (sclk_fall) begin
          d.so_oe = 1'b0;
          if (q.i2_cnt == 4'h8) begin
            unique case (q.i2_st)
              I2C_DEV: begin
                if (q.rx8[7:1] == (mo_s ? `MHSP_I2C_ID1 :
                                          `MHSP_I2C_ID0) >> 1) begin
                  d.so_oe = 1'b1;
                  d.i2_st = q.rx8[0] ? I2C_RD : I2C_REG;
                  rd_go   = q.rx8[0];
                end else begin
                  d.i2_st = I2C_IDLE;
                end
              end
              I2C_REG: begin
                d.so_oe = 1'b1;
                d.addr  = q.rx8;
                d.i2_st = I2C_WR;
              end
              I2C_WR: begin
                d.so_oe = 1'b1;
                wr_go   = 1'b1;
                wb      = q.rx8;
              end
              I2C_RD, I2C_IDLE: d.so_oe = 1'b0;
            endcase
          end else if (q.i2_st == I2C_RD && q.i2_cnt != 4'h0) begin
            d.so_oe = ~q.tx[7];
            d.tx    = {q.tx[6:0], 1'b0};
          end
          if (q.i2_cnt == 4'h9) d.i2_cnt = 4'h0;
        end
      end
      if (rd_done) d.tx = rdat;
    end

    // uart receiver, sampled at mid-bit
    if (q.mode == MHSP_UART) begin
      if (q.rx_cnt != 16'h0000) d.rx_cnt = q.rx_cnt - 16'h0001;
      unique case (q.rx_st)
        RX_IDLE: if (q.ss_p && !ss_s) begin
          d.rx_st  = RX_START;
          d.rx_cnt = 16'(BIT_CYC / 2 - 1);
        end
        RX_START: if (q.rx_cnt == 16'h0000) begin
          d.rx_st  = ss_s ? RX_IDLE : RX_DATA;
          d.rx_cnt = 16'(BIT_CYC - 1);
          d.rx_bit = 3'h0;
        end
        RX_DATA: if (q.rx_cnt == 16'h0000) begin
          d.rx_sh  = {ss_s, q.rx_sh[7:1]};
          d.rx_bit = q.rx_bit + 3'h1;
          d.rx_cnt = 16'(BIT_CYC - 1);
          if (q.rx_bit == 3'h7) d.rx_st = RX_STOP;
        end
        // no recovery: a bad stop bit simply drops the byte
        RX_STOP: if (q.rx_cnt == 16'h0000) begin
          d.rx_st = RX_IDLE;
          rx_byte = ss_s;
        end
      endcase

      unique case (q.u_st)
        U_SKIP: if (rx_byte) d.u_st = U_CMD;
        U_CMD: if (rx_byte && !cts_hold) begin
          d.u_op  = mhsp_uop_t'(q.rx_sh[`MHSP_CMD_OP]);
          d.u_cnt = q.rx_sh[`MHSP_CMD_CNT];
          if (q.rx_sh[`MHSP_CMD_OP] != 2'b11) d.u_st = U_ADDR;
        end
        U_ADDR: if (rx_byte) begin
          d.addr = q.rx_sh;
          unique case (q.u_op)
            UOP_WR:   d.u_st = U_WR;
            UOP_BRST: d.u_st = U_RDC;
            UOP_RD:   d.u_st = U_RDO;
            UOP_STOP: d.u_st = U_CMD;
          endcase
        end
        U_WR: if (rx_byte) begin
          wr_go = 1'b1;
          wb    = q.rx_sh;
          if (q.u_cnt == 6'h00) d.u_st = U_CMD;
          else d.u_cnt = q.u_cnt - 6'h01;
        end
        U_RDO: if (rx_byte && !cts_hold &&
                   q.rx_sh[`MHSP_CMD_OP] == 2'b11) begin
          d.u_st = U_DRAIN;
        end
        U_DRAIN: if (!tx_busy && !q.tx_go && !q.u_pend) begin
          d.u_st   = U_CMD;
          d.u_have = 1'b0;
        end
        U_RDC: ;
      endcase

      // prefetch one byte so characters follow back to back
      if ((q.u_st == U_RDC || q.u_st == U_RDO) &&
          !q.u_pend && !q.u_have) begin
        rd_go    = 1'b1;
        d.u_pend = 1'b1;
      end
      if (rd_done && q.u_pend) begin
        d.u_pend = 1'b0;
        d.u_have = (q.u_st == U_RDC || q.u_st == U_RDO);
        d.tx     = rdat;
      end
      if (q.u_have && !tx_busy && !q.tx_go && !cts_hold &&
          (q.u_st == U_RDC || q.u_st == U_RDO)) begin
        d.tx_go  = 1'b1;
        d.u_have = 1'b0;
        if (q.u_st == U_RDC) begin
          if (q.u_cnt == 6'h00) d.u_st = U_DRAIN;
          else d.u_cnt = q.u_cnt - 6'h01;
        end
      end
      d.sclk_o = txd_w;
      d.mo_o   = cts_hold || q.u_st == U_RDC ||
                 q.u_st == U_DRAIN;
      d.so_oe  = 1'b0;
    end
    d.sclk_oe = (q.mode == MHSP_UART);
    d.mo_oe   = (q.mode == MHSP_UART);
    if (q.mode == MHSP_NONE) d.so_oe = 1'b0;

    //--------------------------------------------------------------------
    // shared register and frame store access
    //--------------------------------------------------------------------
    if (rd_go) begin
      if (q.addr == `MHSP_FS_RD_OFS) begin
        d.fs_rd = 1'b1;
      end else begin
        d.loc_rd   = (q.addr == `MHSP_SEL_OFS);
        d.reg_rd   = (q.addr != `MHSP_SEL_OFS);
        d.reg_addr = q.addr;
        d.addr     = mhsp_inc(q.addr);
      end
    end
    if (wr_go) begin
      if (q.addr == `MHSP_FS_WR_OFS) begin
        d.pk   = {wb, q.pk[55:8]};
        d.pk_n = q.pk_n + 3'h1;
        if (q.pk_n == 3'h7) begin
          d.fs_wr    = 1'b1;
          d.fs_wdata = {wb, q.pk};
        end
      end else begin
        if (q.addr == `MHSP_SEL_OFS) d.fc_en = wb[`MHSP_FLOW_BIT];
        d.reg_wr    = (q.addr != `MHSP_SEL_OFS);
        d.reg_addr  = q.addr;
        d.reg_wdata = wb;
        d.addr      = mhsp_inc(q.addr);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q        <= '0;
      q.fc_en  <= `MHSP_FLOW_RST;
      q.mode   <= MHSP_NONE;
      q.sclk_p <= 1'b1;
      q.sda_p  <= 1'b1;
      q.ss_p   <= 1'b1;
      q.sclk_o <= 1'b1;
      q.mo_o   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign port_serial_clock_o  = q.sclk_o;
  assign port_serial_clock_oe = q.sclk_oe;
  assign port_master_out_o    = q.mo_o;
  assign port_master_out_oe   = q.mo_oe;
  assign port_slave_out_o     = q.so_o;
  assign port_slave_out_oe    = q.so_oe;
  assign reg_addr  = q.reg_addr;
  assign reg_wdata = q.reg_wdata;
  assign reg_wr    = q.reg_wr;
  assign reg_rd    = q.reg_rd;
  assign fs_rd     = q.fs_rd;
  assign fs_wr     = q.fs_wr;
  assign fs_wdata  = q.fs_wdata;

  //----------------------------------------------------------------------
  // checks
  //----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_fs_fetch;
    q.fs_rd |-> $past(q.addr) == `MHSP_FS_RD_OFS && q.addr == $past(q.addr);
  endproperty
  a_fs_fetch: assert property (p_fs_fetch) else $error("fetch moved addr");
  property p_qword;
    q.fs_wr |-> $past(q.pk_n) == 3'h7 && q.pk_n == 3'h0;
  endproperty
  a_qword: assert property (p_qword) else $error("quad write early");
  property p_inc;
    (q.reg_rd || q.reg_wr) |-> q.addr == mhsp_inc(q.reg_addr);
  endproperty
  a_inc: assert property (p_inc) else $error("no auto increment");
  property p_spi_out;
    q.mode == MHSP_SPI && $past(q.mode) == MHSP_SPI &&
      q.so_o != $past(q.so_o) |-> $past(sclk_fall);
  endproperty
  a_spi_out: assert property (p_spi_out) else $error("miso off edge");
  property p_i2c_nostretch;
    q.mode == MHSP_I2C ##1 q.mode == MHSP_I2C |-> !q.sclk_oe && !q.mo_oe;
  endproperty
  a_i2c_nostretch: assert property (p_i2c_nostretch)
    else $error("i2c drove scl");
  property p_cts;
    q.tx_go |-> !$past(cts_hold);
  endproperty
  a_cts: assert property (p_cts) else $error("sent while held");
  property p_rts;
    q.mode == MHSP_UART && q.u_st == U_RDC |=> q.mo_o;
  endproperty
  a_rts: assert property (p_rts) else $error("rts low while busy");
  property p_wr_end;
    q.mode == MHSP_UART && q.u_st == U_WR && rx_byte && q.u_cnt == 6'h00
      |=> q.u_st == U_CMD && (q.reg_wr || q.fs_wr || q.pk_n != 3'h0 ||
                              q.fc_en == $past(q.rx_sh[`MHSP_FLOW_BIT]));
  endproperty
  a_wr_end: assert property (p_wr_end) else $error("write end lost");

  c_fs_write: cover property (q.fs_wr);
  c_spi_read: cover property (q.mode == MHSP_SPI && q.fs_rd);
  c_i2c_read: cover property (q.i2_st == I2C_RD && q.reg_rd);
  c_uart_drain: cover property (q.u_st == U_DRAIN ##1 q.u_st == U_CMD);
endmodule : mhsp_port
`default_nettype wire

// *** bench/mhsp_host_model.sv ***
// host processor model: spi master in mode 0,0 and uart master
`timescale 1ns/1ps
`default_nettype none
module mhsp_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic txd
);
  // ------------------------------------------------------------
  // frame engine, 48 ns link clock period
  // ------------------------------------------------------------
  localparam int HALF = 24;
  // bench bit time: 40 clocks of 5 ns instead of the 1 us of the pin
  localparam int BIT_NS = 200;
  logic [7:0] rxq[$];
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // bytes leave msb first; the port samples on rising edges
  task automatic frame(input logic [7:0] txq[$]);
    logic [7:0] r;
    rxq = {};
    cs_n = 1'b0;
    #HALF;
    foreach (txq[i]) begin
      for (int b = 7; b >= 0; b--) begin
        mosi = txq[i][b];
        #HALF;
        sclk = 1'b1;
        // miso lags a falling edge by the pin sync, so sample late
        #(HALF - 1);
        r[b] = miso;
        #1;
        sclk = 1'b0;
      end
      rxq.push_back(r);
    end
    #HALF;
    cs_n = 1'b1;
    mosi = ~mosi; // no pull on this line, so never a stale level
    #100;
  endtask : frame
  // uart character on the receive pin: start, eight bits lsb first, stop
  task automatic uart_byte(input logic [7:0] b);
    cs_n = 1'b0;
    #BIT_NS;
    for (int i = 0; i < 8; i++) begin
      cs_n = b[i];
      #BIT_NS;
    end
    cs_n = 1'b1;
    #BIT_NS;
  endtask : uart_byte
  // returns at mid-bit of the stop bit, before the next start
  task automatic uart_get(output logic [7:0] b);
    @(negedge txd);
    #(BIT_NS + BIT_NS / 2);
    for (int i = 0; i < 8; i++) begin
      b[i] = txd;
      #BIT_NS;
    end
  endtask : uart_get
endmodule : mhsp_host_model
`default_nettype wire

// *** bench/mhsp_port_bench.sv ***
// self-checking bench of the host port, spi and uart paths with register model
`timescale 1ns/1ps
`default_nettype none
module mhsp_port_bench;
  import mhsp_pkg::*;
  logic        sys_clk, rst, reg_wr, fs_rd, fs_wr;
  logic [1:0]  detected_mode;
  logic        port_serial_clock_i, port_master_out_i, port_select_rx_i;
  logic        port_slave_out_i, port_slave_out_o;
  logic        txd, rts, rts_busy;
  logic [7:0]  ub[2];
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, fs_rdata;
  logic [63:0] fs_wdata, quad;
  logic [7:0]  mem[256];
  logic [7:0]  dat[8];
  logic [7:0]  txq[$];
  logic [63:0] fsw_q[$];
  int          exp_mem[256];
  int          err_count, comparisons, cycles, wr_hits, base, hits0;
  // ------------------------------------------------------------
  // design, host model and internal register responder
  // ------------------------------------------------------------
  mhsp_port #(.BIT_CYC(40)) i_mhsp_port (
    .detected_mode, .sys_clk, .rst, .port_serial_clock_i,
    .port_serial_clock_o(txd), .port_serial_clock_oe(), .port_master_out_i,
    .port_master_out_o(rts), .port_master_out_oe(), .port_slave_out_i,
    .port_slave_out_o, .port_slave_out_oe(), .port_select_rx_i,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd(), .reg_rdata, .fs_rd,
    .fs_rdata, .fs_wr, .fs_wdata);
  mhsp_host_model i_host (.sclk(port_serial_clock_i),
    .cs_n(port_select_rx_i), .mosi(port_master_out_i),
    .miso(port_slave_out_o), .txd(txd));
  assign reg_rdata = mem[reg_addr];
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (reg_wr) begin
      mem[reg_addr] <= reg_wdata;
      wr_hits++;
    end
    if (rst) fs_rdata <= 8'hA0;
    else if (fs_rd) fs_rdata <= fs_rdata + 8'h01;
    if (fs_wr) fsw_q.push_back(fs_wdata);
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end
  // ------------------------------------------------------------
  // compare, transfer and closing tasks
  // ------------------------------------------------------------
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t byte got %h exp %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_quad(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t quad got %h exp %h", $time, got, exp);
    end
  endtask : chk_quad
  task automatic spi_op(input logic [7:0] op, input logic [7:0] a,
                        input int n);
    txq = {op, a, 8'h00};
    for (int i = 0; i < n; i++) txq.push_back(op[7] ? dat[i] : 8'h00);
    i_host.frame(txq);
  endtask : spi_op
  task automatic stop_test();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    detected_mode = 2'b01;
    port_slave_out_i = 1'b1;
    foreach (mem[i]) mem[i] = 8'h00;
    foreach (exp_mem[i]) exp_mem[i] = 0;
    void'($urandom(32579));
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (10) @(posedge sys_clk);
    // burst write then burst read back at a random base
    // keep the burst clear of 0x50, 0x56 and 0xCC
    base = 16 + ($urandom % 48);
    for (int i = 0; i < 4; i++) begin
      dat[i] = 8'($urandom);
      exp_mem[base + i] = dat[i];
    end
    spi_op(8'h80, 8'(base), 4);
    spi_op(8'h00, 8'(base), 4);
    for (int i = 0; i < 4; i++)
      chk_byte(i_host.rxq[3 + i], 8'(exp_mem[base + i]));
    // select register: only bit 2 writable, mode bits read only
    hits0 = wr_hits;
    for (int v = 0; v < 2; v++) begin
      dat[0] = v ? 8'h00 : 8'hFF;
      spi_op(8'h80, 8'h50, 1);
      spi_op(8'h00, 8'h50, 1);
      chk_byte(i_host.rxq[3], v ? 8'h01 : 8'h05);
    end
    chk_byte(8'(wr_hits - hits0), 8'h00);
    // frame store fetch keeps returning successive bytes
    spi_op(8'h00, 8'hCC, 3);
    for (int i = 0; i < 3; i++)
      chk_byte(i_host.rxq[3 + i], 8'(8'hA0 + i));
    // eight bytes to the write port give one quad word
    hits0 = wr_hits;
    quad = 64'h0;
    for (int i = 0; i < 8; i++) begin
      dat[i] = 8'($urandom);
      quad = quad | (64'(dat[i]) << (8 * i));
    end
    spi_op(8'h80, 8'h56, 8);
    repeat (8) @(posedge sys_clk);
    chk_byte(8'(fsw_q.size()), 8'h01);
    chk_quad(fsw_q.size() > 0 ? fsw_q[0] : 64'h0, quad);
    chk_byte(8'(wr_hits - hits0), 8'h00);
    // second reset switches to uart; cts stays high but is not observed
    rst <= 1'b1;
    detected_mode <= 2'b10;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (10) @(posedge sys_clk);
    i_host.uart_byte(8'h00);
    for (int i = 0; i < 2; i++) begin
      dat[i] = 8'($urandom);
      exp_mem[base + i] = dat[i];
    end
    i_host.uart_byte(8'h41);
    i_host.uart_byte(8'(base));
    for (int i = 0; i < 2; i++) i_host.uart_byte(dat[i]);
    i_host.uart_byte(8'h01);
    fork
      i_host.uart_byte(8'(base));
      begin
        i_host.uart_get(ub[0]);
        rts_busy = rts;
        i_host.uart_get(ub[1]);
      end
    join
    for (int i = 0; i < 2; i++)
      chk_byte(ub[i], 8'(exp_mem[base + i]));
    chk_byte({7'h00, rts_busy}, 8'h01);
    repeat (100) @(posedge sys_clk);
    chk_byte({7'h00, rts}, 8'h00);
    stop_test();
  end
endmodule : mhsp_port_bench
`default_nettype wire
